// ===== rbs_pkg.sv
// Package with constants, types and register map for the reset and boot sequencer.
package rbs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_HOST_CTRL = 8'h08;
    localparam int CTRL_HOST_INT_BIT = 0;
    localparam int CTRL_SDRAM_EN_BIT = 1;
    localparam int HPC_INT_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [1:0] BOOT_NONE = 2'h0;
    localparam logic [1:0] BOOT_HOST = 2'h1;
    localparam logic [1:0] BOOT_ROM = 2'h2;
    localparam logic [31:0] ROM_BASE = 32'h0000_0000;
    localparam logic [31:0] BOOT_DEST = 32'h0000_0000;
    localparam int ROM_BYTES = 1024;
    localparam int ROM_WORDS = ROM_BYTES / 4;
    localparam logic [8:0] ROM_WORDS_W = 9'h100;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic we;
    } rbs_mem_req_t;
endpackage

// ===== rbs_seq.sv
// Reset and boot sequencer with ROM copy, host boot stall and emulation select capture.
`timescale 1ns/1ps
module rbs_seq
    import rbs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] boot_sel,
    input wire logic pci_en_strap,
    input wire logic big_endian,
    input wire logic sdram_init_done,
    input wire logic trst_n_pin,
    input wire logic trst_n_driven,
    input wire logic [1:0] emulation_select_pins,
    output logic cpu_stall,
    output logic periph_reset_n,
    output logic [31:0] cpu_start_addr,
    output logic host_via_pci,
    output logic host_via_parallel,
    output logic cpu_int_pending,
    output logic emu_reset_n,
    output logic [1:0] emu_mode,
    output logic rom_rd_req,
    output logic [31:0] rom_rd_addr,
    input wire logic rom_rd_valid,
    input wire logic [7:0] rom_rd_data,
    output rbs_mem_req_t mem_req,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    input wire logic cpu_int_clear,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_HOST = 5'h02,
        ST_ROM = 5'h04,
        ST_SDRAM = 5'h08,
        ST_RUN = 5'h10
    } rbs_state_t;

    rbs_state_t state_reg, state_next;
    logic [1:0] mode_reg;
    logic pci_reg;
    logic host_int_reg;
    logic sdram_en_reg;
    logic int_pend_reg;
    logic [9:0] byte_cnt_reg;
    logic [31:0] pack_reg;
    logic [1:0] lane_reg;
    logic wr_pend_reg;
    logic [8:0] word_cnt_reg;
    logic rd_out_reg;
    logic [1:0] trst_sync_reg;
    logic [3:0] emu_sync_reg;
    logic trst_prev_reg;
    logic [1:0] emu_mode_reg;
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // Test reset is an active-low pin with an internal pulldown when nothing drives it.
    wire trst_pin_level = trst_n_driven & trst_n_pin;
    wire trst_n = trst_sync_reg[1];
    wire trst_rise = trst_n & ~trst_prev_reg;
    wire copy_done = (word_cnt_reg == ROM_WORDS_W) && !wr_pend_reg;
    wire byte_in = rom_rd_valid && rd_out_reg;
    wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_ctrl = wr_go && awaddr_reg == OFF_CTRL;
    wire wr_hpc = wr_go && awaddr_reg == OFF_HOST_CTRL;
    wire wr_hit = wr_ctrl || wr_hpc;
    wire host_set = wr_hpc && wstrb_reg[0] && wdata_reg[HPC_INT_BIT];
    wire host_clr = cpu_int_clear;
    // The flow is decoded from the pins in the release cycle, as it is stored.
    wire [1:0] sel_flow = (boot_sel == 2'h3) ? BOOT_NONE : boot_sel;
    wire rd_go = s_axi_arvalid && !rvalid_reg;
    wire [31:0] status_word = {21'h0, emu_mode_reg, pci_reg, mode_reg,
                               cpu_stall, state_reg};
    wire [31:0] hpc_word = {30'h0, host_int_reg, 1'b0};
    wire [31:0] ctrl_word = {30'h0, sdram_en_reg, 1'b0};
    wire rd_hit = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_STATUS)
                  || (s_axi_araddr == OFF_HOST_CTRL);
    wire [31:0] rd_word = (s_axi_araddr == OFF_STATUS) ? status_word :
                          (s_axi_araddr == OFF_HOST_CTRL) ? hpc_word :
                          (s_axi_araddr == OFF_CTRL) ? ctrl_word : 32'h0;
    // Image bytes fill lanes in the system byte order.
    wire [4:0] lane_pos = big_endian ? {~lane_reg, 3'h0} : {lane_reg, 3'h0};

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET: begin
                if (sel_flow == BOOT_HOST) begin
                    state_next = ST_HOST;
                end else if (sel_flow == BOOT_ROM) begin
                    state_next = ST_ROM;
                end else begin
                    state_next = ST_SDRAM;
                end
            end
            ST_HOST: begin
                if (host_int_reg && mode_reg == BOOT_HOST) begin
                    state_next = ST_RUN;
                end
            end
            ST_ROM: begin
                if (copy_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_SDRAM: begin
                if (sdram_init_done || !sdram_en_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_RESET;
        endcase
    end

    // Whole state is forced to defined values while reset is low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // The flow and port straps are caught in the first cycle after release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= BOOT_NONE;
            pci_reg <= 1'b0;
        end else if (state_reg == ST_RESET) begin
            mode_reg <= sel_flow;
            pci_reg <= pci_en_strap;
        end
    end

    // Host interrupt bit: set wins over clear; further sets ignored while set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_int_reg <= 1'b0;
            // SDRAM counts as present until software clears the enable bit.
            sdram_en_reg <= 1'b1;
            int_pend_reg <= 1'b0;
        end else begin
            if (host_set) begin
                host_int_reg <= 1'b1;
            end else if (host_clr) begin
                host_int_reg <= 1'b0;
            end
            if (wr_ctrl && wstrb_reg[0]) begin
                sdram_en_reg <= wdata_reg[CTRL_SDRAM_EN_BIT];
            end
            if (host_set && !host_int_reg && !cpu_stall) begin
                int_pend_reg <= 1'b1;
            end else if (host_clr) begin
                int_pend_reg <= 1'b0;
            end
        end
    end

    // ROM copy: one automatic block of bytes packed into words at address 0.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_cnt_reg <= 10'h000;
            word_cnt_reg <= 9'h000;
            lane_reg <= 2'h0;
            pack_reg <= 32'h0;
            wr_pend_reg <= 1'b0;
            rd_out_reg <= 1'b0;
        end else begin
            if (state_reg == ST_ROM && !rd_out_reg && !wr_pend_reg
                && word_cnt_reg != ROM_WORDS_W) begin
                rd_out_reg <= 1'b1;
            end else if (byte_in) begin
                rd_out_reg <= 1'b0;
            end
            if (byte_in) begin
                pack_reg[lane_pos +: 8] <= rom_rd_data;
                lane_reg <= lane_reg + 2'h1;
                byte_cnt_reg <= byte_cnt_reg + 10'h001;
                if (lane_reg == 2'h3) begin
                    wr_pend_reg <= 1'b1;
                end
            end else if (wr_pend_reg && mem_req_ready) begin
                wr_pend_reg <= 1'b0;
                word_cnt_reg <= word_cnt_reg + 9'h001;
            end
        end
    end

    // Test reset edge latches the emulation select pins after core release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trst_sync_reg <= 2'h0;
            emu_sync_reg <= 4'h0;
            trst_prev_reg <= 1'b0;
            emu_mode_reg <= 2'h0;
        end else begin
            trst_sync_reg <= {trst_sync_reg[0], trst_pin_level};
            emu_sync_reg <= {emu_sync_reg[1:0], emulation_select_pins};
            trst_prev_reg <= trst_n;
            if (trst_rise) begin
                emu_mode_reg <= emu_sync_reg[3:2];
            end
        end
    end

    // Register slave; address and data may arrive in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    assign cpu_stall = state_reg != ST_RUN;
    assign periph_reset_n = state_reg != ST_RESET;
    assign cpu_start_addr = BOOT_DEST;
    assign host_via_pci = (mode_reg == BOOT_HOST) && pci_reg;
    assign host_via_parallel = (mode_reg == BOOT_HOST) && !pci_reg;
    assign cpu_int_pending = int_pend_reg;
    assign emu_reset_n = trst_n;
    assign emu_mode = emu_mode_reg;
    assign rom_rd_req = rd_out_reg;
    assign rom_rd_addr = ROM_BASE + {22'h0, byte_cnt_reg};
    assign mem_req_valid = wr_pend_reg;
    assign mem_req = '{addr: BOOT_DEST + {21'h0, word_cnt_reg, 2'h0}, data: pack_reg, we: 1'b1};

    a_stall_host_int: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_ROM && host_int_reg && !copy_done) |=> cpu_stall)
        else $error("Stall lifted outside host flow.");
    a_host_release: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_HOST && host_int_reg) |=> !cpu_stall)
        else $error("Host bit did not release stall.");
    a_no_pend_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        (host_set && cpu_stall && !int_pend_reg) |=> !int_pend_reg)
        else $error("Interrupt latched during stall.");
    a_rom_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_ROM && !copy_done) |=> cpu_stall)
        else $error("CPU ran before copy done.");
    a_rom_done: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_ROM && copy_done) |=> (!cpu_stall && word_cnt_reg == ROM_WORDS_W))
        else $error("Copy completion did not release stall.");
    a_pack_word: assert property (@(posedge aclk) disable iff (!aresetn)
        (byte_in && lane_reg == 2'h3) |=> mem_req_valid)
        else $error("Packed word not issued.");
    a_mode_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg != ST_RESET) |=> $stable(mode_reg))
        else $error("Boot mode changed after release.");
    a_emu_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        trst_rise |=> emu_mode_reg == $past(emu_sync_reg[3:2]))
        else $error("Emulation select not latched.");
    a_sdram_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_SDRAM && sdram_en_reg && !sdram_init_done) |=> cpu_stall)
        else $error("CPU ran before memory init.");
    a_reset_state: assert property (@(posedge aclk)
        !aresetn |=> (state_reg == ST_RESET && !periph_reset_n))
        else $error("Reset state not forced.");

    c_host_boot: cover property (@(posedge aclk) state_reg == ST_HOST ##1 state_reg == ST_RUN);
    c_rom_boot: cover property (@(posedge aclk) state_reg == ST_ROM ##1 state_reg == ST_RUN);
    c_sdram_boot: cover property (@(posedge aclk) state_reg == ST_SDRAM ##1 state_reg == ST_RUN);
    c_emu_latch: cover property (@(posedge aclk) trst_rise);
endmodule // rbs_seq

// ===== rbs_rom_model.sv
// Boot ROM and internal memory model that serves the sequencer's copy traffic.
`timescale 1ns/1ps
module rbs_rom_model
    import rbs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic rom_rd_req,
    input wire logic [31:0] rom_rd_addr,
    output logic rom_rd_valid,
    output logic [7:0] rom_rd_data,
    input wire rbs_mem_req_t mem_req,
    input wire logic mem_req_valid,
    output logic mem_req_ready
);
    logic [1:0] wait_reg;
    logic go;
    logic [31:0] mem [ROM_WORDS];
    int wr_count;
    // Each byte of the image encodes its own offset, stored in system byte order.
    assign go = rom_rd_req && !rom_rd_valid && (wait_reg == (slow ? 2'h2 : 2'h0));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rom_rd_valid <= 1'b0;
            rom_rd_data <= 8'hFF;
            wait_reg <= 2'h0;
            mem_req_ready <= 1'b0;
            wr_count <= 0;
        end else begin
            rom_rd_valid <= go;
            rom_rd_data <= go ? (rom_rd_addr[7:0] ^ {6'h00, rom_rd_addr[9:8]}) : ~rom_rd_data;
            wait_reg <= (go || !rom_rd_req || rom_rd_valid) ? 2'h0 : wait_reg + 2'h1;
            mem_req_ready <= slow ? ~mem_req_ready : 1'b1;
            if (mem_req_valid && mem_req_ready && mem_req.we) begin
                mem[mem_req.addr[9:2]] <= mem_req.data;
                wr_count <= wr_count + 1;
            end
        end
    end
endmodule // rbs_rom_model

// ===== reset_boot_sequencer_tb_top.sv
// Self-checking testbench for the reset and boot sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module reset_boot_sequencer_tb_top
    import rbs_pkg::*;
;
    localparam logic [31:0] INT_SET = 32'h1 << HPC_INT_BIT;
    logic aclk = 1'b0, aresetn = 1'b0, pci_en_strap = 1'b0, big_endian = 1'b0;
    logic sdram_init_done = 1'b0, cpu_int_clear = 1'b0, slow = 1'b0;
    logic trst_n_pin = 1'b0, trst_n_driven = 1'b0;
    logic [1:0] boot_sel = BOOT_NONE, emulation_select_pins = 2'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, emu_mode, resp;
    logic cpu_stall, periph_reset_n, host_via_pci, host_via_parallel, cpu_int_pending;
    logic emu_reset_n, rom_rd_req, rom_rd_valid, mem_req_valid, mem_req_ready;
    logic [31:0] cpu_start_addr, rom_rd_addr, s_axi_rdata, rd;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0] rom_rd_data;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    rbs_mem_req_t mem_req;
    int failures = 0, checks_done = 0, cycles = 0;

    rbs_seq uut (.aclk, .aresetn, .boot_sel, .pci_en_strap, .big_endian, .sdram_init_done,
        .trst_n_pin, .trst_n_driven, .emulation_select_pins, .cpu_stall, .periph_reset_n,
        .cpu_start_addr, .host_via_pci, .host_via_parallel, .cpu_int_pending, .emu_reset_n,
        .emu_mode, .rom_rd_req, .rom_rd_addr, .rom_rd_valid, .rom_rd_data, .mem_req,
        .mem_req_valid, .mem_req_ready, .cpu_int_clear, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rbs_rom_model rom (.aclk, .aresetn, .slow, .rom_rd_req, .rom_rd_addr, .rom_rd_valid,
        .rom_rd_data, .mem_req, .mem_req_valid, .mem_req_ready);

    always #2.5 aclk = ~aclk;
    // The ceiling covers two ROM copies, the slow one at about five cycles per byte.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] sel, input logic strap, input logic be);
        @(posedge aclk);
        aresetn <= 1'b0;
        boot_sel <= sel;
        pci_en_strap <= strap;
        big_endian <= be;
        repeat (10) @(posedge aclk);
        `CHK(cpu_stall, 1'b1)
        `CHK(periph_reset_n, 1'b0)
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) failures++;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) failures++;
    endtask

    task automatic wait_stall(input int lim);
        int n;
        n = 0;
        while (cpu_stall !== 1'b0 && n < lim) begin
            @(posedge aclk);
            n++;
        end
    endtask

    function automatic logic [31:0] exp_word(input int j, input logic be);
        logic [7:0] b [4];
        for (int k = 0; k < 4; k++) b[k] = 8'(4 * j + k) ^ {6'h00, 2'((4 * j + k) >> 8)};
        return be ? {b[0], b[1], b[2], b[3]} : {b[3], b[2], b[1], b[0]};
    endfunction

    task automatic run_none();
        for (int s = 0; s < 4; s += 3) begin
            sdram_init_done <= s[0];
            do_reset(2'(s), 1'b0, 1'b0);
            `CHK(cpu_stall, !s[0])
            if (!s[0]) axi_wr(OFF_CTRL, 32'h0, resp);
            wait_stall(4);
            `CHK(cpu_stall, 1'b0)
            `CHK(cpu_start_addr, BOOT_DEST)
        end
    endtask

    task automatic run_host();
        for (int p = 0; p < 2; p++) begin
            do_reset(BOOT_HOST, p[0], 1'b0);
            `CHK(cpu_stall, 1'b1)
            `CHK(periph_reset_n, 1'b1)
            `CHK(host_via_pci, p[0])
            `CHK(host_via_parallel, ~p[0])
            axi_wr(OFF_CTRL, 32'h0, resp);
            axi_wr(8'h40, 32'h0, resp);
            `CHK(resp, RESP_DECERR)
            axi_rd(8'h40, rd, resp);
            `CHK(resp, RESP_DECERR)
            axi_wr(OFF_HOST_CTRL, INT_SET, resp);
            `CHK(resp, RESP_OKAY)
            wait_stall(4);
            `CHK(cpu_stall, 1'b0)
            repeat (2) @(posedge aclk);
            `CHK(cpu_int_pending, 1'b0)
            axi_rd(OFF_HOST_CTRL, rd, resp);
            `CHK(rd[HPC_INT_BIT], 1'b1)
            axi_wr(OFF_HOST_CTRL, INT_SET, resp);
            repeat (2) @(posedge aclk);
            `CHK(cpu_int_pending, 1'b0)
            cpu_int_clear <= 1'b1;
            @(posedge aclk);
            cpu_int_clear <= 1'b0;
            axi_wr(OFF_HOST_CTRL, INT_SET, resp);
            repeat (2) @(posedge aclk);
            `CHK(cpu_int_pending, 1'b1)
        end
    endtask

    task automatic run_rom();
        for (int b = 0; b < 2; b++) begin
            slow <= b[0];
            do_reset(BOOT_ROM, 1'b0, b[0]);
            boot_sel <= BOOT_HOST;
            axi_wr(OFF_HOST_CTRL, INT_SET, resp);
            `CHK(cpu_stall, 1'b1)
            wait_stall(10000);
            `CHK(cpu_stall, 1'b0)
            `CHK(rom.wr_count, ROM_WORDS)
            `CHK(rom.mem[0], exp_word(0, b[0]))
            `CHK(rom.mem[ROM_WORDS - 1], exp_word(ROM_WORDS - 1, b[0]))
        end
    endtask

    task automatic run_emu();
        trst_n_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(emu_reset_n, 1'b0)
        for (int m = 1; m < 3; m++) begin
            trst_n_driven <= 1'b0;
            emulation_select_pins <= 2'(m);
            repeat (4) @(posedge aclk);
            trst_n_driven <= 1'b1;
            repeat (6) @(posedge aclk);
            emulation_select_pins <= 2'(3 - m);
            repeat (6) @(posedge aclk);
            `CHK(emu_reset_n, 1'b1)
            `CHK(emu_mode, 2'(m))
        end
    endtask

    initial begin
        run_none();
        run_host();
        run_rom();
        run_emu();
        give_verdict();
    end
endmodule // reset_boot_sequencer_tb_top
